// file: dv/access_master.sv
// Fieldbus master model: one access at a time on the request port
`timescale 1ns/100ps
module access_master (
  input wire logic clk_sys, // Clock
  output logic acc_req, // Request pulse
  output logic acc_write, // Write flag
  output logic [15:0] acc_index, // Index
  output logic [7:0] acc_subindex, // Subindex
  output logic [31:0] acc_wdata, // Write data
  input wire logic acc_done, // Accepted
  input wire logic acc_abort, // Refused
  input wire logic [31:0] acc_rdata, // Read data
  input wire logic [7:0] acc_rlen // Byte count
);
  initial begin
    acc_req = 1'b0;
    acc_write = 1'b0;
    acc_index = 16'h0;
    acc_subindex = 8'h0;
    acc_wdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
                      output logic [1:0] st, output logic [31:0] r, output logic [7:0] n);
    @(negedge clk_sys);
    acc_req = 1'b1;
    acc_write = w;
    acc_index = i;
    acc_subindex = s;
    acc_wdata = d;
    @(negedge clk_sys);
    // Pulse request; released lines flip so stale values never look valid
    acc_req = 1'b0;
    acc_write = ~w;
    acc_index = ~i;
    acc_subindex = ~s;
    acc_wdata = ~d;
    st = {acc_done, acc_abort};
    r = acc_rdata;
    n = acc_rlen;
  endtask : xfer
endmodule : access_master

// file: dv/drive_info_config_objects_bench.sv
// Testbench: object reads, writes and refusals through the access port
`timescale 1ns/100ps
module drive_info_config_objects_bench;
  import drive_info_pkg::*;
  logic clk_sys, rst_b, acc_req, acc_write, acc_done, acc_abort, error_push, ballast_on;
  logic [15:0] acc_index, last_error, ident_octets;
  logic [7:0] acc_subindex, acc_rlen;
  logic [31:0] acc_wdata, acc_rdata, eeprom_bytes, boot_version, boot_fieldbus, boot_hardware_group;
  logic [31:0] error_entry, hw_config, serial_text;
  logic signed [31:0] supply_mv, logic_mv, board_temp, power_supply_voltage;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  drive_info_objects #(.SERIAL_LEN(4), .IDENT_LEN(2)) dut (.*);
  access_master m (.*);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // ==========================================
  // Checking tasks
  task chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
           input logic [1:0] es, input logic [7:0] en, input logic [31:0] e);
    logic [1:0] st;
    logic [31:0] r;
    logic [7:0] n;
    m.xfer(w, i, s, d, st, r, n);
    chk({st, n, r}, {es, en, e});
  endtask : acc
  task rd(input logic [15:0] i, input logic [7:0] s, input logic [7:0] en, input logic [31:0] e);
    acc(1'b0, i, s, 32'h0, 2'b10, en, e);
  endtask : rd
  task wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
    acc(1'b1, i, s, d, 2'b10, 8'h0, 32'h0);
  endtask : wr
  task ab(input logic w, input logic [15:0] i, input logic [7:0] s);
    acc(w, i, s, 32'h0000_0001, 2'b01, 8'h0, 32'h0);
  endtask : ab
  task settle;
    // Two sync flops plus the comparator register
    repeat (3) @(negedge clk_sys);
  endtask : settle
  task close_out;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      close_out();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    error_push = 1'b0;
    error_entry = 32'h0;
    eeprom_bytes = 32'h0;
    supply_mv = 32'sd48000;
    logic_mv = 32'sd24000;
    board_temp = -32'sd125;
    boot_version = 32'h0004_0002;
    boot_fieldbus = 32'h0000_0005;
    boot_hardware_group = 32'h0000_0011;
    serial_text = "AB12";
    ident_octets = 16'hc3d4;
    repeat (6) @(negedge clk_sys);
    rst_b = 1'b1;
    rd(IDX_HW_INFO, SUB_1, 8'h4, 32'h0);
    rd(IDX_HW_INFO, SUB_COUNT, 8'h1, 32'h1);
    rd(IDX_HW_CONFIG, SUB_COUNT, 8'h1, 32'h1);
    ab(1'b1, IDX_HW_CONFIG, SUB_COUNT);
    eeprom_bytes = 32'h0000_0800;
    settle();
    rd(IDX_HW_INFO, SUB_1, 8'h4, 32'h0000_0800);
    ab(1'b1, IDX_HW_INFO, SUB_1);
    rd(IDX_HW_CONFIG, SUB_1, 8'h4, 32'h0);
    wr(IDX_HW_CONFIG, SUB_1, 32'ha5a5_0f0f);
    rd(IDX_HW_CONFIG, SUB_1, 8'h4, 32'ha5a5_0f0f);
    chk(hw_config, 32'ha5a5_0f0f);
    rd(IDX_OP_COND, SUB_COUNT, 8'h1, 32'h5);
    rd(IDX_OP_COND, SUB_1, 8'h4, 32'd48000);
    rd(IDX_OP_COND, SUB_2, 8'h4, 32'd24000);
    rd(IDX_OP_COND, SUB_3, 8'h4, 32'hffff_ff83);
    rd(IDX_OP_COND, SUB_4, 8'h4, 32'h0);
    rd(IDX_OP_COND, SUB_5, 8'h4, 32'h0);
    ab(1'b1, IDX_OP_COND, SUB_1);
    rd(IDX_OP_COND, SUB_1, 8'h4, 32'd48000);
    rd(IDX_BALLAST, SUB_COUNT, 8'h1, 32'h3);
    rd(IDX_BALLAST, SUB_1, 8'h4, 32'h1);
    rd(IDX_BALLAST, SUB_2, 8'h4, 32'h0000_c019);
    rd(IDX_BALLAST, SUB_3, 8'h4, 32'h0000_01f4);
    ab(1'b1, IDX_BALLAST, SUB_COUNT);
    // Threshold 49177, release point 48677
    supply_mv = 32'sd50000;
    settle();
    chk(ballast_on, 1'b1);
    chk(power_supply_voltage, 32'd50000);
    supply_mv = 32'sd49000;
    settle();
    chk(ballast_on, 1'b1);
    supply_mv = 32'sd48000;
    settle();
    chk(ballast_on, 1'b0);
    supply_mv = 32'sd50000;
    settle();
    wr(IDX_BALLAST, SUB_1, 32'h0);
    @(negedge clk_sys);
    chk(ballast_on, 1'b0);
    wr(IDX_BALLAST, SUB_1, 32'h1);
    settle();
    chk(ballast_on, 1'b1);
    wr(IDX_BALLAST, SUB_2, 32'h0000_ea60);
    rd(IDX_BALLAST, SUB_2, 8'h4, 32'h0000_ea60);
    settle();
    chk(ballast_on, 1'b0);
    wr(IDX_BALLAST, SUB_3, 32'h0000_0064);
    rd(IDX_BALLAST, SUB_3, 8'h4, 32'h0000_0064);
    rd(IDX_BOOT_INFO, SUB_COUNT, 8'h1, 32'h3);
    rd(IDX_BOOT_INFO, SUB_1, 8'h4, 32'h0004_0002);
    rd(IDX_BOOT_INFO, SUB_2, 8'h4, 32'h0000_0005);
    rd(IDX_BOOT_INFO, SUB_3, 8'h4, 32'h0000_0011);
    ab(1'b1, IDX_BOOT_INFO, SUB_1);
    rd(IDX_SERIAL, 8'h0, 8'h1, 32'h32);
    rd(IDX_SERIAL, 8'h3, 8'h1, 32'h41);
    ab(1'b0, IDX_SERIAL, 8'h4);
    ab(1'b1, IDX_SERIAL, 8'h0);
    rd(IDX_IDENTITY, 8'h1, 8'h1, 32'hc3);
    ab(1'b0, IDX_IDENTITY, 8'h2);
    ab(1'b1, IDX_IDENTITY, 8'h0);
    rd(IDX_LAST_ERROR, SUB_COUNT, 8'h2, 32'h0);
    error_entry = 32'h1234_8611;
    error_push = 1'b1;
    @(negedge clk_sys);
    error_push = 1'b0;
    rd(IDX_LAST_ERROR, SUB_COUNT, 8'h2, 32'h0000_8611);
    error_entry = 32'hffff_5530;
    error_push = 1'b1;
    @(negedge clk_sys);
    error_push = 1'b0;
    rd(IDX_LAST_ERROR, SUB_COUNT, 8'h2, 32'h0000_5530);
    chk(last_error, 16'h5530);
    ab(1'b0, IDX_LAST_ERROR, SUB_1);
    ab(1'b1, IDX_LAST_ERROR, SUB_COUNT);
    // Mid-run reset must bring back every preset
    rst_b = 1'b0;
    @(negedge clk_sys);
    rst_b = 1'b1;
    chk(hw_config, 32'h0);
    chk(last_error, 16'h0);
    chk(ballast_on, 1'b0);
    rd(IDX_BALLAST, SUB_1, 8'h4, 32'h1);
    rd(IDX_BALLAST, SUB_2, 8'h4, 32'h0000_c019);
    rd(IDX_BALLAST, SUB_3, 8'h4, 32'h0000_01f4);
    rd(IDX_HW_CONFIG, SUB_1, 8'h4, 32'h0);
    ab(1'b0, 16'h4015, SUB_COUNT);
    close_out();
  end
endmodule : drive_info_config_objects_bench

// file: dv/drive_info_props_properties.sv
// Checker: access answers, read-only refusals and register side effects
`timescale 1ns/100ps
module drive_info_props import drive_info_pkg::*; (
  input wire logic clk_sys, // Clock
  input wire logic rst_b, // Reset, low
  input wire logic acc_req, // Request
  input wire logic acc_write, // Write flag
  input wire logic [15:0] acc_index, // Index
  input wire logic [7:0] acc_subindex, // Subindex
  input wire logic [31:0] acc_wdata, // Write data
  input wire logic acc_done, // Accepted
  input wire logic acc_abort, // Refused
  input wire logic [31:0] acc_rdata, // Read data
  input wire logic [7:0] acc_rlen, // Byte count
  input wire logic error_push, // New error
  input wire logic [31:0] error_entry, // Error entry
  input wire logic [31:0] hw_config, // Config word
  input wire logic ballast_on, // Ballast drive
  input wire logic [15:0] last_error // Error code
);
  logic [15:0] err_lo;
  assign err_lo = error_entry[15:0];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  answer_once_a: assert property (acc_req |=> acc_done != acc_abort)
    else $error("request not answered exactly once");
  idle_quiet_a: assert property (!acc_req |=> !acc_done && !acc_abort)
    else $error("answer without request");
  abort_clear_a: assert property (acc_abort |-> acc_rdata == 32'h0 && acc_rlen == 8'h0)
    else $error("refusal carries data");
  op_read_only_a: assert property (
    acc_req && acc_write && acc_index == IDX_OP_COND |=> acc_abort) else $error("condition write taken");
  ballast_count_a: assert property (
    acc_req && !acc_write && acc_index == IDX_BALLAST && acc_subindex == SUB_COUNT
    |=> acc_done && acc_rdata == 32'h3 && acc_rlen == 8'h1) else $error("ballast count wrong");
  op_count_a: assert property (
    acc_req && !acc_write && acc_index == IDX_OP_COND && acc_subindex == SUB_COUNT
    |=> acc_done && acc_rdata == 32'h5) else $error("condition count wrong");
  error_capture_a: assert property (error_push |=> last_error == $past(err_lo))
    else $error("error code not captured");
  error_read_a: assert property (
    acc_req && !acc_write && acc_index == IDX_LAST_ERROR && acc_subindex == SUB_COUNT && !error_push
    |=> acc_rdata == {16'h0, last_error}) else $error("error code read wrong");
  ballast_off_a: assert property (
    acc_req && acc_write && acc_index == IDX_BALLAST && acc_subindex == SUB_1 && !acc_wdata[0]
    |-> ##2 !ballast_on) else $error("ballast stays on");
  config_store_a: assert property (
    acc_req && acc_write && acc_index == IDX_HW_CONFIG && acc_subindex == SUB_1
    |=> hw_config == $past(acc_wdata)) else $error("config word not stored");
endmodule : drive_info_props
bind drive_info_objects drive_info_props props (.*);

// file: logic/ballast_switch.sv
// Ballast comparator with hysteresis
`timescale 1ns/100ps
module ballast_switch import drive_info_pkg::*; (
  input wire logic clk_sys, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic enable, // Ballast enabled by software
  input wire logic signed [31:0] supply_mv, // Supply voltage, mV
  input wire logic [31:0] limit_mv, // Switch threshold, mV
  input wire logic [31:0] hyst_mv, // Hysteresis, mV
  output logic active // Ballast on
);
  logic active_q;
  logic [32:0] low_mark;
  logic signed [33:0] sup_ext;

  // Clamp at zero so a large hysteresis cannot wrap the release level
  assign low_mark = (hyst_mv > limit_mv) ? 33'h0_0000_0000 : {1'b0, limit_mv - hyst_mv};
  assign sup_ext = {{2{supply_mv[31]}}, supply_mv};

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      active_q <= 1'b0;
    end else if (!enable) begin
      active_q <= 1'b0;
    end else if (sup_ext > $signed({2'b00, limit_mv})) begin
      active_q <= 1'b1;
    end else if (sup_ext < $signed({1'b0, low_mark})) begin
      active_q <= 1'b0;
    end
  end
  assign active = active_q;
endmodule : ballast_switch

// file: logic/drive_info_objects.sv
// Object dictionary entries: hardware info, operating conditions, ballast, identity, boot, last error
//
// Contract
// - EEPROM byte size read-only, zero if absent
// - Hardware config word read/write, preset zero
// - Subindex 1 returns supply voltage in mV
// - Subindex 2 returns logic voltage in mV
// - Subindex 3 returns board temperature, tenth degrees
// - Five subentries; subindices 4, 5 read zero
// - Operating conditions refuse all writes with an abort
// - Ballast bit 0 switches ballast, preset on
// - Ballast threshold read/write, preset 0xc019
// - Ballast hysteresis read/write, preset 0x1f4
// - Ballast subindex 0 reports three entries
// - Boot version: major high, minor low half
// - Boot supported fieldbus bit field
// - Error code shows most recent error
// - Error code is low 16 error-field bits
// - Serial number read-only visible string
// - Identity read-only octet string
`timescale 1ns/100ps
module drive_info_objects import drive_info_pkg::*; #(
  parameter int SERIAL_LEN = SERIAL_LEN_DEF, // Serial string length, bytes
  parameter int IDENT_LEN = IDENT_LEN_DEF // Identity string length, bytes
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic acc_req, // Access request pulse
  input wire logic acc_write, // 1 write, 0 read
  input wire logic [15:0] acc_index, // Object index
  input wire logic [7:0] acc_subindex, // Subindex, or byte number for strings
  input wire logic [31:0] acc_wdata, // Write data
  output logic acc_done, // Access complete pulse
  output logic acc_abort, // Access refused pulse
  output logic [31:0] acc_rdata, // Read data
  output logic [7:0] acc_rlen, // Valid bytes in read data
  input wire logic [31:0] eeprom_bytes, // Attached EEPROM size, 0 if none
  input wire logic signed [31:0] supply_mv, // Measured supply voltage
  input wire logic signed [31:0] logic_mv, // Measured logic voltage
  input wire logic signed [31:0] board_temp, // Board temperature, 0.1 C
  input wire logic [31:0] boot_version, // Bootloader version word
  input wire logic [31:0] boot_fieldbus, // Bootloader fieldbus mask
  input wire logic [31:0] boot_hardware_group, // Bootloader hardware group
  input wire logic [8*SERIAL_LEN-1:0] serial_text, // Serial number characters
  input wire logic [8*IDENT_LEN-1:0] ident_octets, // Identity octets
  input wire logic error_push, // New error entry pulse
  input wire logic [31:0] error_entry, // Newest error field entry
  output logic [31:0] hw_config, // Hardware config word
  output logic ballast_on, // Ballast stage drive
  output logic signed [31:0] power_supply_voltage, // Process data copy of supply
  output logic [15:0] last_error // Last error code
);
  // ==========================================================
  // Parameter check
  initial begin
    if (SERIAL_LEN < 1 || SERIAL_LEN > 255 || IDENT_LEN < 1 || IDENT_LEN > 255) begin
      $error("String length out of range");
    end
  end

  // ==========================================================
  // Input synchronisers for measured and strapped values
  logic [31:0] eep_s1_q, eep_s2_q;
  logic [31:0] sup_s1_q, sup_s2_q, log_s1_q, log_s2_q, tmp_s1_q, tmp_s2_q;
  logic [31:0] bv_s1_q, bv_s2_q, bf_s1_q, bf_s2_q, bg_s1_q, bg_s2_q;

  // Multi-bit values may tear for one sample; they change slowly
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      eep_s1_q <= 32'h0;
      eep_s2_q <= 32'h0;
      sup_s1_q <= 32'h0;
      sup_s2_q <= 32'h0;
      log_s1_q <= 32'h0;
      log_s2_q <= 32'h0;
      tmp_s1_q <= 32'h0;
      tmp_s2_q <= 32'h0;
      bv_s1_q <= RST_BOOT_WORD;
      bv_s2_q <= RST_BOOT_WORD;
      bf_s1_q <= RST_BOOT_WORD;
      bf_s2_q <= RST_BOOT_WORD;
      bg_s1_q <= RST_BOOT_WORD;
      bg_s2_q <= RST_BOOT_WORD;
    end else begin
      eep_s1_q <= eeprom_bytes;
      eep_s2_q <= eep_s1_q;
      sup_s1_q <= supply_mv;
      sup_s2_q <= sup_s1_q;
      log_s1_q <= logic_mv;
      log_s2_q <= log_s1_q;
      tmp_s1_q <= board_temp;
      tmp_s2_q <= tmp_s1_q;
      bv_s1_q <= boot_version;
      bv_s2_q <= bv_s1_q;
      bf_s1_q <= boot_fieldbus;
      bf_s2_q <= bf_s1_q;
      bg_s1_q <= boot_hardware_group;
      bg_s2_q <= bg_s1_q;
    end
  end

  // ==========================================================
  // Writable entries
  logic [31:0] hw_config_q;
  logic [31:0] ballast_set_q, ballast_limit_q, ballast_hyst_q;
  logic wr_ok;
  logic rd_ok;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hw_config_q <= RST_HW_CONFIG;
    end else if (acc_req && acc_write && wr_ok && acc_index == IDX_HW_CONFIG) begin
      hw_config_q <= acc_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ballast_set_q <= RST_BALLAST_SET;
      ballast_limit_q <= RST_BALLAST_LIMIT;
      ballast_hyst_q <= RST_BALLAST_HYST;
    end else if (acc_req && acc_write && wr_ok && acc_index == IDX_BALLAST) begin
      case (acc_subindex)
        SUB_1: ballast_set_q <= acc_wdata;
        SUB_2: ballast_limit_q <= acc_wdata;
        SUB_3: ballast_hyst_q <= acc_wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Last error code
  logic [15:0] last_error_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      last_error_q <= 16'h0000;
    end else if (error_push) begin
      last_error_q <= error_entry[ERROR_CODE_W-1:0];
    end
  end

  // ==========================================================
  // Ballast comparator
  logic ballast_act;
  ballast_switch u_ballast (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .enable(ballast_set_q[BALLAST_ON_BIT]),
    .supply_mv(sup_s2_q),
    .limit_mv(ballast_limit_q),
    .hyst_mv(ballast_hyst_q),
    .active(ballast_act)
  );

  // ==========================================================
  // Read decode and write permission
  logic [31:0] rd_val;
  logic [7:0] rd_len;

  always_comb begin
    rd_val = 32'h0;
    rd_len = 8'h04;
    rd_ok = 1'b1;
    wr_ok = 1'b0;
    case (acc_index)
      IDX_HW_INFO: begin
        case (acc_subindex)
          SUB_COUNT: begin
            rd_val = {24'h0, CNT_HW_INFO};
            rd_len = 8'h01;
          end
          SUB_1: rd_val = eep_s2_q;
          default: rd_ok = 1'b0;
        endcase
      end
      IDX_HW_CONFIG: begin
        case (acc_subindex)
          SUB_COUNT: begin
            rd_val = {24'h0, CNT_HW_CONFIG};
            rd_len = 8'h01;
          end
          SUB_1: begin
            rd_val = hw_config_q;
            wr_ok = 1'b1;
          end
          default: rd_ok = 1'b0;
        endcase
      end
      IDX_OP_COND: begin
        // No subindex here is writable
        case (acc_subindex)
          SUB_COUNT: begin
            rd_val = {24'h0, CNT_OP_COND};
            rd_len = 8'h01;
          end
          SUB_1: rd_val = sup_s2_q;
          SUB_2: rd_val = log_s2_q;
          SUB_3: rd_val = tmp_s2_q;
          SUB_4: rd_val = RST_RESERVED_TEMP;
          SUB_5: rd_val = RST_RESERVED_TEMP;
          default: rd_ok = 1'b0;
        endcase
      end
      IDX_BALLAST: begin
        case (acc_subindex)
          SUB_COUNT: begin
            rd_val = {24'h0, CNT_BALLAST};
            rd_len = 8'h01;
          end
          SUB_1: begin
            rd_val = ballast_set_q;
            wr_ok = 1'b1;
          end
          SUB_2: begin
            rd_val = ballast_limit_q;
            wr_ok = 1'b1;
          end
          SUB_3: begin
            rd_val = ballast_hyst_q;
            wr_ok = 1'b1;
          end
          default: rd_ok = 1'b0;
        endcase
      end
      IDX_SERIAL: begin
        // Byte n of the string read at subindex n; read only
        if (acc_subindex < 8'(SERIAL_LEN)) begin
          rd_val = {24'h0, serial_text[8*acc_subindex +: 8]};
          rd_len = 8'h01;
        end else begin
          rd_ok = 1'b0;
        end
      end
      IDX_IDENTITY: begin
        if (acc_subindex < 8'(IDENT_LEN)) begin
          rd_val = {24'h0, ident_octets[8*acc_subindex +: 8]};
          rd_len = 8'h01;
        end else begin
          rd_ok = 1'b0;
        end
      end
      IDX_BOOT_INFO: begin
        case (acc_subindex)
          SUB_COUNT: begin
            rd_val = {24'h0, CNT_BOOT_INFO};
            rd_len = 8'h01;
          end
          SUB_1: rd_val = bv_s2_q;
          SUB_2: rd_val = bf_s2_q;
          SUB_3: rd_val = bg_s2_q;
          default: rd_ok = 1'b0;
        endcase
      end
      IDX_LAST_ERROR: begin
        rd_val = {16'h0, last_error_q};
        rd_len = 8'h02;
        rd_ok = (acc_subindex == SUB_COUNT);
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // ==========================================================
  // Answer sequencing: one cycle after the request
  access_state_e state_q;
  logic [31:0] rdata_q;
  logic [7:0] rlen_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      rdata_q <= 32'h0;
      rlen_q <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE, ST_RESP, ST_ABORT: begin
          if (!acc_req) begin
            state_q <= ST_IDLE;
          end else if (acc_write ? !wr_ok : !rd_ok) begin
            state_q <= ST_ABORT;
            rdata_q <= 32'h0;
            rlen_q <= 8'h00;
          end else begin
            state_q <= ST_RESP;
            rdata_q <= acc_write ? 32'h0 : rd_val;
            rlen_q <= acc_write ? 8'h00 : rd_len;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Registered side outputs
  logic signed [31:0] pdo_supply_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pdo_supply_q <= 32'sh0;
    end else begin
      pdo_supply_q <= sup_s2_q;
    end
  end

  assign acc_done = state_q[1];
  assign acc_abort = state_q[2];
  assign acc_rdata = rdata_q;
  assign acc_rlen = rlen_q;
  assign hw_config = hw_config_q;
  assign ballast_on = ballast_act;
  assign power_supply_voltage = pdo_supply_q;
  assign last_error = last_error_q;
endmodule : drive_info_objects

// file: logic/drive_info_pkg.sv
// Package: object indices, subindex layout, presets and widths of the drive info block
package drive_info_pkg;
  // Object indices
  localparam logic [15:0] IDX_HW_INFO = 16'h4012;
  localparam logic [15:0] IDX_HW_CONFIG = 16'h4013;
  localparam logic [15:0] IDX_OP_COND = 16'h4014;
  localparam logic [15:0] IDX_BALLAST = 16'h4021;
  localparam logic [15:0] IDX_SERIAL = 16'h4040;
  localparam logic [15:0] IDX_IDENTITY = 16'h4041;
  localparam logic [15:0] IDX_BOOT_INFO = 16'h4042;
  localparam logic [15:0] IDX_LAST_ERROR = 16'h603f;
  // Subentry counts reported in subindex 0
  localparam logic [7:0] CNT_HW_INFO = 8'h01;
  localparam logic [7:0] CNT_HW_CONFIG = 8'h01;
  localparam logic [7:0] CNT_OP_COND = 8'h05;
  localparam logic [7:0] CNT_BALLAST = 8'h03;
  localparam logic [7:0] CNT_BOOT_INFO = 8'h03;
  // Subindex numbers
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_1 = 8'h01;
  localparam logic [7:0] SUB_2 = 8'h02;
  localparam logic [7:0] SUB_3 = 8'h03;
  localparam logic [7:0] SUB_4 = 8'h04;
  localparam logic [7:0] SUB_5 = 8'h05;
  // Preset values
  localparam logic [31:0] RST_HW_CONFIG = 32'h0000_0000;
  localparam logic [31:0] RST_BALLAST_SET = 32'h0000_0001;
  localparam logic [31:0] RST_BALLAST_LIMIT = 32'h0000_c019;
  localparam logic [31:0] RST_BALLAST_HYST = 32'h0000_01f4;
  localparam logic [31:0] RST_RESERVED_TEMP = 32'h0000_0000;
  localparam logic [31:0] RST_BOOT_WORD = 32'h0000_0000;
  // Field positions
  localparam int BALLAST_ON_BIT = 0;
  localparam int BOOT_MAJOR_LSB = 16;
  localparam int ERROR_CODE_W = 16;
  // String widths
  localparam int SERIAL_LEN_DEF = 8;
  localparam int IDENT_LEN_DEF = 8;
  // Access states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RESP = 3'b010,
    ST_ABORT = 3'b100
  } access_state_e;
endpackage : drive_info_pkg
